// file: inc/deser_regs_pkg.sv
// Shared constants and carrier types for the deserializer status/config bank.
// Assumes a 100 MHz ref_clk and an upstream I2C target that issues register requests.
package deser_regs_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_REVISION = 8'h03;
    localparam logic [7:0] ADDR_STATUS   = 8'h04;
    localparam logic [7:0] ADDR_PAR_HI   = 8'h05;
    localparam logic [7:0] ADDR_PAR_LO   = 8'h06;
    localparam logic [7:0] ADDR_WDOG     = 8'h07;
    localparam logic [7:0] ADDR_LBUS     = 8'h08;

    // Values after reset
    localparam logic [7:0] RST_PAR_HI      = 8'h01;
    localparam logic [7:0] RST_PAR_LO      = 8'h00;
    localparam logic [6:0] RST_WDOG_TIMER  = 7'h7F;
    localparam logic       RST_WDOG_OFF    = 1'b0;
    localparam logic       RST_WR_BLOCK    = 1'b0;
    localparam logic [2:0] RST_SDA_HOLD    = 3'h1;
    localparam logic [3:0] RST_FILTER      = 4'hC;

    // Field positions
    localparam int REV_LSB        = 4;
    localparam int STS_CKSUM_BIT  = 7;
    localparam int STS_INIT_BIT   = 6;
    localparam int STS_REFERENCE_CLOCK_INPUT_BIT = 4;
    localparam int STS_PASS_BIT   = 3;
    localparam int STS_LOCK_BIT   = 2;
    localparam logic [1:0] STS_RSVD_LOW = 2'h3;
    localparam int WDOG_TIMER_LSB = 1;
    localparam int WDOG_OFF_BIT   = 0;
    localparam int LBUS_BLOCK_BIT = 7;
    localparam int LBUS_HOLD_LSB  = 4;
    localparam int LBUS_FILT_LSB  = 0;

    // Timing
    localparam int CLK_PERIOD_NS     = 10;
    localparam int WDOG_UNIT_MS      = 2;
    localparam int WDOG_UNIT_CYCLES  = WDOG_UNIT_MS * 1000000 / CLK_PERIOD_NS;
    localparam int SDA_HOLD_STEP_NS  = 40;
    localparam int SDA_HOLD_STEP_CYC = (SDA_HOLD_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FILTER_STEP_NS    = 5;
    localparam int REFERENCE_CLOCK_INPUT_MIN_MHZ    = 12;
    localparam int REFERENCE_CLOCK_INPUT_MAX_MHZ    = 64;
    localparam int REFERENCE_CLOCK_INPUT_DIV        = 8;
    localparam int MEAS_WINDOW_NS    = 10000;
    localparam int MEAS_WINDOW_CYC   = MEAS_WINDOW_NS / CLK_PERIOD_NS;
    localparam int REFERENCE_CLOCK_INPUT_MIN_EVENTS = REFERENCE_CLOCK_INPUT_MIN_MHZ * MEAS_WINDOW_NS / 1000 / REFERENCE_CLOCK_INPUT_DIV;
    localparam int REFERENCE_CLOCK_INPUT_MAX_EVENTS = REFERENCE_CLOCK_INPUT_MAX_MHZ * MEAS_WINDOW_NS / 1000 / REFERENCE_CLOCK_INPUT_DIV;

    // One register access from the I2C target
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       remote;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // Per-port parity event inputs
    typedef struct packed {
        logic [1:0] err;
        logic [1:0] clear;
    } parity_evt_t;

endpackage

// file: verilog/parity_threshold_flag.sv
// One receive port's parity error counter and threshold flag.
// Assumes one-cycle error pulses and a threshold stable in ref_clk.
`timescale 1ns/100ps
module parity_threshold_flag
    import deser_regs_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input  wire logic             ref_clk,
    input  wire logic             reset,
    input  wire logic             err_i,
    input  wire logic             clear_i,
    input  wire logic [CNT_W-1:0] threshold_i,
    output logic                  flag_q
);
    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] count_d;

    // Saturate so a long run never wraps below the threshold
    always_comb begin
        count_d = count_q;
        if (clear_i) begin
            // An error in the clearing cycle still counts
            count_d = CNT_W'(err_i);
        end else if (err_i && (count_q != {CNT_W{1'b1}})) begin
            count_d = count_q + 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= (count_d >= threshold_i);
        end
    end

    a_flag_at_threshold: assert property (@(posedge ref_clk) disable iff (reset)
        (count_q >= threshold_i) && !clear_i |=> flag_q)
        else $error("parity flag not set at threshold");

endmodule

// file: verilog/deser_status_config_regs.sv
// Device status and configuration register bank of the deserializer hub.
// Assumes the I2C target presents one request per cycle; read data follows one cycle later.
`timescale 1ns/100ps
module deser_status_config_regs
    import deser_regs_pkg::*;
#(
    parameter logic [3:0] SILICON_REV_CODE = 4'h5,   // Arbitrary value
    parameter logic [3:0] PHOTOMASK_CODE   = 4'h3,   // Arbitrary value
    parameter int         WDOG_UNIT_CYC    = WDOG_UNIT_CYCLES,
    parameter int         PORTS            = 2
) (
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire reg_req_t    reg_req,
    output logic [7:0]       reg_rdata,
    output logic             reg_rvalid,
    output logic             remote_write_refused,
    input  wire logic        cfg_load_done,
    input  wire logic        cfg_checksum_valid,
    input  wire logic        reference_clock_input_div_toggle,
    input  wire logic        pass_source,
    input  wire logic        lock_source,
    output logic             pass_pin,
    output logic             lock_pin,
    input  wire parity_evt_t parity_evt,
    output logic [PORTS-1:0] parity_error_flag,
    input  wire logic        bc_txn_active,
    output logic             bc_txn_abort,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             scl_filtered,
    output logic             sda_held
);
    localparam int PRESC_W = $clog2(WDOG_UNIT_CYC + 1);
    localparam int HOLD_MAX = 7 * SDA_HOLD_STEP_CYC;

    // Port count is fixed by the two-lane parity event carrier
    if (WDOG_UNIT_CYC < 1 || PORTS != 2) begin : g_bad_param
        $error("unsupported parameter value");
    end


    // Register state
    logic [7:0] thold_hi_q;
    logic [7:0] thold_lo_q;
    logic [6:0] wdog_timer_q;
    logic       wdog_off_q;
    logic       wr_block_q;
    logic [2:0] sda_hold_q;
    logic [3:0] filter_depth_q;
    logic       init_done_q;
    logic       cksum_ok_q;
    logic       reference_clock_input_ok_q;
    logic [15:0] parity_error_threshold;

    logic wr_ok;
    assign wr_ok = reg_req.wr && !(reg_req.remote && wr_block_q);
    assign parity_error_threshold = {thold_hi_q, thold_lo_q};

    // Writable registers; read-only offsets have no write path
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            thold_hi_q     <= RST_PAR_HI;
            thold_lo_q     <= RST_PAR_LO;
            wdog_timer_q   <= RST_WDOG_TIMER;
            wdog_off_q     <= RST_WDOG_OFF;
            wr_block_q     <= RST_WR_BLOCK;
            sda_hold_q     <= RST_SDA_HOLD;
            filter_depth_q <= RST_FILTER;
        end else if (wr_ok) begin
            unique case (reg_req.addr)
                ADDR_PAR_HI: begin
                    thold_hi_q <= reg_req.wdata;
                end
                ADDR_PAR_LO: begin
                    thold_lo_q <= reg_req.wdata;
                end
                ADDR_WDOG: begin
                    wdog_timer_q <= reg_req.wdata[WDOG_TIMER_LSB +: 7];
                    wdog_off_q   <= reg_req.wdata[WDOG_OFF_BIT];
                end
                ADDR_LBUS: begin
                    wr_block_q     <= reg_req.wdata[LBUS_BLOCK_BIT];
                    sda_hold_q     <= reg_req.wdata[LBUS_HOLD_LSB +: 3];
                    filter_depth_q <= reg_req.wdata[LBUS_FILT_LSB +: 4];
                end
                default: begin
                end
            endcase
        end
    end

    // Refusal only reports; the pass-through path to local targets is elsewhere
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            remote_write_refused <= 1'b0;
        end else begin
            remote_write_refused <= reg_req.wr && reg_req.remote && wr_block_q;
        end
    end

    // Read path; reads have no side effects
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_req.rd;
            if (reg_req.rd) begin
                unique case (reg_req.addr)
                    ADDR_REVISION: begin
                        reg_rdata <= {SILICON_REV_CODE, PHOTOMASK_CODE};
                    end
                    ADDR_STATUS: begin
                        reg_rdata <= {cksum_ok_q, init_done_q, 1'b0, reference_clock_input_ok_q,
                                      pass_pin, lock_pin, STS_RSVD_LOW};
                    end
                    ADDR_PAR_HI: begin
                        reg_rdata <= thold_hi_q;
                    end
                    ADDR_PAR_LO: begin
                        reg_rdata <= thold_lo_q;
                    end
                    ADDR_WDOG: begin
                        reg_rdata <= {wdog_timer_q, wdog_off_q};
                    end
                    ADDR_LBUS: begin
                        reg_rdata <= {wr_block_q, sda_hold_q, filter_depth_q};
                    end
                    default: begin
                        reg_rdata <= 8'h00;
                    end
                endcase
            end
        end
    end

    // Initialization status, caught once the loader reports done
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            init_done_q <= 1'b0;
            cksum_ok_q  <= 1'b0;
        end else if (cfg_load_done && !init_done_q) begin
            init_done_q <= 1'b1;
            cksum_ok_q  <= cfg_checksum_valid;
        end
    end

    // Pin mirrors: the status bits read the same flops that drive the pins
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pass_pin <= 1'b0;
            lock_pin <= 1'b0;
        end else begin
            pass_pin <= pass_source;
            lock_pin <= lock_source;
        end
    end

    // Reference clock measurement: divided-clock edges counted over a fixed window of ref_clk cycles
    logic       rc_meta_q;
    logic       rc_sync_q;
    logic       rc_prev_q;
    logic [9:0] win_cnt_q;
    logic [7:0] edge_cnt_q;
    logic       win_end;

    assign win_end = (win_cnt_q == 10'(MEAS_WINDOW_CYC - 1));

    // Divided clock is asynchronous to ref_clk, so it crosses on two flops
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rc_meta_q <= 1'b0;
            rc_sync_q <= 1'b0;
            rc_prev_q <= 1'b0;
        end else begin
            rc_meta_q <= reference_clock_input_div_toggle;
            rc_sync_q <= rc_meta_q;
            rc_prev_q <= rc_sync_q;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            win_cnt_q   <= 10'h000;
            edge_cnt_q  <= 8'h00;
            reference_clock_input_ok_q <= 1'b0;
        end else if (win_end) begin
            win_cnt_q   <= 10'h000;
            edge_cnt_q  <= 8'h00;
            reference_clock_input_ok_q <= (edge_cnt_q >= 8'(REFERENCE_CLOCK_INPUT_MIN_EVENTS)) &&
                           (edge_cnt_q <= 8'(REFERENCE_CLOCK_INPUT_MAX_EVENTS));
        end else begin
            win_cnt_q <= win_cnt_q + 10'h001;
            if ((rc_sync_q != rc_prev_q) && (edge_cnt_q != 8'hFF)) begin
                edge_cnt_q <= edge_cnt_q + 8'h01;
            end
        end
    end

    // Per-port parity threshold flags
    for (genvar p = 0; p < PORTS; p++) begin : g_port
        parity_threshold_flag #(
            .CNT_W       (16)
        ) u_flag (
            .ref_clk     (ref_clk),
            .reset       (reset),
            .err_i       (parity_evt.err[p]),
            .clear_i     (parity_evt.clear[p]),
            .threshold_i (parity_error_threshold),
            .flag_q      (parity_error_flag[p])
        );
    end

    // Back-channel watchdog
    logic [PRESC_W-1:0] presc_q;
    logic [7:0]         units_q;
    logic               fired_q;
    logic               unit_tick;

    assign unit_tick = (presc_q == PRESC_W'(WDOG_UNIT_CYC - 1));

    // A zero timeout would wait a full 256 units; software is told not to use it
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            presc_q      <= '0;
            units_q      <= 8'h00;
            fired_q      <= 1'b0;
            bc_txn_abort <= 1'b0;
        end else if (!bc_txn_active || wdog_off_q) begin
            presc_q      <= '0;
            units_q      <= 8'h00;
            fired_q      <= 1'b0;
            bc_txn_abort <= 1'b0;
        end else begin
            bc_txn_abort <= 1'b0;
            if (!fired_q) begin
                presc_q <= unit_tick ? '0 : presc_q + 1'b1;
                if (unit_tick) begin
                    units_q <= units_q + 8'h01;
                    if ((units_q + 8'h01) == {1'b0, wdog_timer_q}) begin
                        fired_q      <= 1'b1;
                        bc_txn_abort <= 1'b1;
                    end
                end
            end
        end
    end

    // Glitch filters: an input change must persist past the programmed width
    logic [3:0] filt_cyc;
    logic [1:0] line_in;
    logic [1:0] line_q;
    assign filt_cyc = 4'((filter_depth_q * FILTER_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    assign line_in  = {sda_in, scl_in};

    for (genvar l = 0; l < 2; l++) begin : g_filt
        logic [3:0] stable_q;
        always_ff @(posedge ref_clk or posedge reset) begin
            if (reset) begin
                stable_q  <= 4'h0;
                line_q[l] <= 1'b1;
            end else if (line_in[l] == line_q[l]) begin
                stable_q <= 4'h0;
            end else if (stable_q >= filt_cyc) begin
                stable_q  <= 4'h0;
                line_q[l] <= line_in[l];
            end else begin
                stable_q <= stable_q + 4'h1;
            end
        end
    end

    // SDA hold line: delay the filtered SDA by whole 40 ns steps
    logic [HOLD_MAX-1:0] sda_line_q;
    logic [4:0]          hold_cyc;
    assign hold_cyc = 5'(sda_hold_q * SDA_HOLD_STEP_CYC);

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sda_line_q   <= '1;
            sda_held     <= 1'b1;
            scl_filtered <= 1'b1;
        end else begin
            sda_line_q   <= {sda_line_q[HOLD_MAX-2:0], line_q[1]};
            sda_held     <= (hold_cyc == 5'h00) ? line_q[1] : sda_line_q[hold_cyc - 5'h01];
            scl_filtered <= line_q[0];
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    a_rev_readback: assert property (reg_req.rd && reg_req.addr == ADDR_REVISION |=>
        reg_rdata == {SILICON_REV_CODE, PHOTOMASK_CODE})
        else $error("identification read wrong");
    a_pass_mirror: assert property (reg_req.rd && reg_req.addr == ADDR_STATUS |=>
        reg_rdata[STS_PASS_BIT] == $past(pass_pin))
        else $error("pass status differs from pin");
    a_lock_mirror: assert property (reg_req.rd && reg_req.addr == ADDR_STATUS |=>
        reg_rdata[STS_LOCK_BIT] == $past(lock_pin))
        else $error("lock status differs from pin");
    a_init_done_set: assert property (cfg_load_done && !init_done_q |=>
        init_done_q && cksum_ok_q == $past(cfg_checksum_valid))
        else $error("init status not captured");
    a_reference_clock_input_range: assert property (win_end |=>
        reference_clock_input_ok_q == ($past(edge_cnt_q) >= 8'(REFERENCE_CLOCK_INPUT_MIN_EVENTS) &&
                        $past(edge_cnt_q) <= 8'(REFERENCE_CLOCK_INPUT_MAX_EVENTS)))
        else $error("reference clock verdict wrong");
    a_remote_blocked: assert property (reg_req.wr && reg_req.remote && wr_block_q &&
        reg_req.addr == ADDR_PAR_LO |=> $stable(thold_lo_q))
        else $error("remote write not blocked");
    a_local_write: assert property (reg_req.wr && !reg_req.remote &&
        reg_req.addr == ADDR_PAR_LO |=> thold_lo_q == $past(reg_req.wdata))
        else $error("local write lost");
    a_thold_default: assert property ($past(reset) |-> parity_error_threshold == 16'h0100)
        else $error("threshold reset value wrong");
    a_wdog_stopped: assert property (wdog_off_q || !bc_txn_active |=> !bc_txn_abort)
        else $error("abort while watchdog stopped");
    a_wdog_abort: assert property (bc_txn_active && !wdog_off_q && unit_tick && !fired_q &&
        (units_q + 8'h01) == {1'b0, wdog_timer_q} |=> bc_txn_abort)
        else $error("watchdog did not abort");
    a_status_stable: assert property (reg_req.rd && !reg_req.wr |=>
        $stable(init_done_q) || $past(cfg_load_done))
        else $error("read changed status");

    c_abort: cover property (bc_txn_abort);
    c_reference_clock_input_ok: cover property ($rose(reference_clock_input_ok_q));
    c_parity_flag: cover property ($rose(parity_error_flag[0]));
    c_refused: cover property (remote_write_refused);

endmodule

// file: testbench/reference_clock_input_source_model.sv
// Far-side model of the divided reference clock that feeds the bank.
// Assumes ref_clk at 100 MHz; half_cyc of zero stops the toggle.
`timescale 1ns/100ps
module reference_clock_input_source_model (
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic [7:0] half_cyc,
    output logic            reference_clock_input_div_toggle
);
    logic [7:0] cnt_q;

    // Stands still when not commanded, as an absent oscillator would
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cnt_q             <= 8'h00;
            reference_clock_input_div_toggle <= 1'b0;
        end else if (half_cyc == 8'h00) begin
            cnt_q <= 8'h00;
        end else if (cnt_q + 8'h01 >= half_cyc) begin
            cnt_q             <= 8'h00;
            reference_clock_input_div_toggle <= ~reference_clock_input_div_toggle;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
endmodule

// file: testbench/testbench.sv
// Self-checking bench for the status and configuration bank.
// Assumes the package constants and a small watchdog unit of 4 cycles.
`timescale 1ns/100ps
module testbench;
    import deser_regs_pkg::*;
    localparam logic [3:0] REV  = 4'h5;   // Arbitrary value
    localparam logic [3:0] MASK = 4'h3;   // Arbitrary value

    logic        ref_clk, reset, reg_rvalid, remote_write_refused;
    logic        cfg_load_done, cfg_checksum_valid, reference_clock_input_div_toggle;
    logic        pass_source, lock_source, pass_pin, lock_pin;
    logic        bc_txn_active, bc_txn_abort, scl_in, sda_in, scl_filtered, sda_held;
    logic [7:0]  reg_rdata, half_cyc;
    logic [1:0]  parity_error_flag;
    reg_req_t    reg_req;
    parity_evt_t parity_evt;
    int          fails, total_checks;

    deser_status_config_regs #(.SILICON_REV_CODE(REV), .PHOTOMASK_CODE(MASK),
        .WDOG_UNIT_CYC(4), .PORTS(2)) DUT (
        .ref_clk(ref_clk), .reset(reset), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .remote_write_refused(remote_write_refused),
        .cfg_load_done(cfg_load_done), .cfg_checksum_valid(cfg_checksum_valid),
        .reference_clock_input_div_toggle(reference_clock_input_div_toggle), .pass_source(pass_source),
        .lock_source(lock_source), .pass_pin(pass_pin), .lock_pin(lock_pin),
        .parity_evt(parity_evt), .parity_error_flag(parity_error_flag),
        .bc_txn_active(bc_txn_active), .bc_txn_abort(bc_txn_abort), .scl_in(scl_in),
        .sda_in(sda_in), .scl_filtered(scl_filtered), .sda_held(sda_held));

    reference_clock_input_source_model reference_clock_input_src (.ref_clk(ref_clk), .reset(reset), .half_cyc(half_cyc),
        .reference_clock_input_div_toggle(reference_clock_input_div_toggle));

    always #5 ref_clk = ~ref_clk;

    task automatic results();
        if (fails == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Writes return the refused pulse in bit 0
    task automatic acc(input logic w, input logic rem, input logic [7:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        @(posedge ref_clk);
        reg_req <= '{wr: w, rd: !w, remote: rem, addr: a, wdata: d};
        @(posedge ref_clk);
        reg_req <= '0;
        @(negedge ref_clk);
        q = w ? {7'h00, remote_write_refused} : reg_rdata;
        if (!w) chk("rvalid", 8'h01, {7'h00, reg_rvalid});
    endtask

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] q;
        acc(1'b0, 1'b0, a, 8'h00, q);
        chk(nm, exp, q);
    endtask

    task automatic t_reset();
        logic [7:0] ad [6] = '{ADDR_REVISION, ADDR_STATUS, ADDR_PAR_HI, ADDR_PAR_LO,
                               ADDR_WDOG, 8'h20};
        logic [7:0] ex [6] = '{{REV, MASK}, 8'h03, 8'h01, 8'h00, 8'hFE, 8'h00};
        foreach (ad[i]) rdchk("reset_value", ad[i], ex[i]);
        rdchk("lbus_reset", ADDR_LBUS, 8'h1C);
    endtask

    task automatic t_rw();
        logic [7:0] q;
        acc(1'b1, 1'b0, ADDR_REVISION, 8'hFF, q);
        acc(1'b1, 1'b0, ADDR_STATUS, 8'hFC, q);
        rdchk("rev_ro", ADDR_REVISION, {REV, MASK});
        rdchk("sts_ro", ADDR_STATUS, 8'h03);
        acc(1'b1, 1'b0, ADDR_WDOG, 8'h81, q);
        rdchk("wdog_rw", ADDR_WDOG, 8'h81);
        acc(1'b1, 1'b0, ADDR_LBUS, 8'h2B, q);
        rdchk("lbus_rw", ADDR_LBUS, 8'h2B);
        acc(1'b1, 1'b0, ADDR_LBUS, 8'h1C, q);
    endtask

    task automatic t_init();
        logic [7:0] q;
        @(posedge ref_clk);
        cfg_load_done <= 1'b1;
        @(posedge ref_clk);
        cfg_load_done      <= 1'b0;
        cfg_checksum_valid <= 1'b0;
        acc(1'b0, 1'b0, ADDR_STATUS, 8'h00, q);
        chk("init_cksum", 8'h03, {6'h00, q[7:6]});
        acc(1'b0, 1'b0, ADDR_STATUS, 8'h00, q);
        chk("init_reread", 8'h03, {6'h00, q[7:6]});
    endtask

    task automatic t_pins();
        logic [7:0] q;
        for (int i = 0; i < 4; i++) begin
            @(posedge ref_clk);
            pass_source <= i[1];
            lock_source <= i[0];
            repeat (2) @(posedge ref_clk);
            acc(1'b0, 1'b0, ADDR_STATUS, 8'h00, q);
            chk("pass_lock_bits", {6'h00, pass_pin, lock_pin}, {6'h00, q[3:2]});
            chk("pins", {6'h00, i[1:0]}, {6'h00, pass_pin, lock_pin});
        end
    endtask

    task automatic t_reference_clock_input();
        logic [7:0] q;
        logic [7:0] hc [3] = '{8'd20, 8'd5, 8'd100};
        logic       ok [3] = '{1'b1, 1'b0, 1'b0};
        foreach (hc[i]) begin
            @(posedge ref_clk);
            half_cyc <= hc[i];
            repeat (2100) @(posedge ref_clk);
            acc(1'b0, 1'b0, ADDR_STATUS, 8'h00, q);
            chk("reference_clock_input_ok", {7'h00, ok[i]}, {7'h00, q[STS_REFERENCE_CLOCK_INPUT_BIT]});
        end
    endtask

    task automatic pulse(input logic [1:0] e, input logic [1:0] c);
        @(posedge ref_clk);
        parity_evt <= '{err: e, clear: c};
        @(posedge ref_clk);
        parity_evt <= '0;
        @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    task automatic t_parity();
        logic [7:0] q;
        acc(1'b1, 1'b0, ADDR_PAR_HI, 8'h00, q);
        acc(1'b1, 1'b0, ADDR_PAR_LO, 8'h03, q);
        pulse(2'b01, 2'b00);
        pulse(2'b01, 2'b00);
        chk("flag_below", 8'h00, {6'h00, parity_error_flag});
        pulse(2'b11, 2'b00);
        chk("flag_reached", 8'h01, {6'h00, parity_error_flag});
        pulse(2'b00, 2'b01);
        chk("flag_cleared", 8'h00, {6'h00, parity_error_flag});
    endtask

    task automatic t_remote();
        logic [7:0] q;
        acc(1'b1, 1'b0, ADDR_LBUS, 8'h9C, q);
        acc(1'b1, 1'b1, ADDR_PAR_LO, 8'h77, q);
        chk("refused", 8'h01, q);
        rdchk("remote_blocked", ADDR_PAR_LO, 8'h03);
        acc(1'b1, 1'b0, ADDR_PAR_LO, 8'h44, q);
        chk("local_refused", 8'h00, q);
        rdchk("local_taken", ADDR_PAR_LO, 8'h44);
        acc(1'b1, 1'b0, ADDR_LBUS, 8'h1C, q);
        acc(1'b1, 1'b1, ADDR_PAR_LO, 8'h66, q);
        rdchk("remote_taken", ADDR_PAR_LO, 8'h66);
    endtask

    task automatic glitch(output logic seen);
        @(posedge ref_clk);
        scl_in <= 1'b0;
        repeat (2) @(posedge ref_clk);
        scl_in <= 1'b1;
        seen = 1'b0;
        repeat (15) begin
            @(negedge ref_clk);
            if (scl_filtered === 1'b0) seen = 1'b1;
        end
    endtask

    task automatic t_filter();
        logic [7:0] q;
        logic       seen;
        int         ns, nd;
        glitch(seen);
        chk("glitch_rejected", 8'h00, {7'h00, seen});
        @(posedge ref_clk);
        scl_in <= 1'b0;
        sda_in <= 1'b0;
        ns = 0;
        nd = 0;
        for (int i = 1; i < 60; i++) begin
            @(negedge ref_clk);
            if (ns == 0 && scl_filtered === 1'b0) ns = i;
            if (nd == 0 && sda_held === 1'b0) nd = i;
        end
        chk("sda_hold_extra", 8'(SDA_HOLD_STEP_CYC), 8'(nd - ns));
        @(posedge ref_clk);
        scl_in <= 1'b1;
        sda_in <= 1'b1;
        repeat (40) @(posedge ref_clk);
        acc(1'b1, 1'b0, ADDR_LBUS, 8'h10, q);
        glitch(seen);
        chk("depth_zero_passes", 8'h01, {7'h00, seen});
    endtask

    task automatic t_wdog();
        logic [7:0] q;
        int         n;
        acc(1'b1, 1'b0, ADDR_WDOG, 8'h04, q);
        @(posedge ref_clk);
        bc_txn_active <= 1'b1;
        n = 0;
        for (int i = 1; i < 30 && n == 0; i++) begin
            @(negedge ref_clk);
            if (bc_txn_abort === 1'b1) n = i;
        end
        chk("abort_at_timeout", 8'h01, {7'h00, n >= 8 && n <= 10});
        n = 0;
        repeat (20) begin
            @(negedge ref_clk);
            if (bc_txn_abort !== 1'b0) n++;
        end
        chk("single_abort", 8'h00, 8'(n));
        @(posedge ref_clk);
        bc_txn_active <= 1'b0;
        acc(1'b1, 1'b0, ADDR_WDOG, 8'h05, q);
        @(posedge ref_clk);
        bc_txn_active <= 1'b1;
        repeat (30) begin
            @(negedge ref_clk);
            if (bc_txn_abort !== 1'b0) n++;
        end
        chk("disabled_no_abort", 8'h00, 8'(n));
        @(posedge ref_clk);
        bc_txn_active <= 1'b0;
    endtask

    // Second reset in mid-run; checksum now reported bad
    task automatic t_cksum_bad();
        logic [7:0] q;
        @(posedge ref_clk);
        reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        cfg_load_done <= 1'b1;
        @(posedge ref_clk);
        cfg_load_done <= 1'b0;
        acc(1'b0, 1'b0, ADDR_STATUS, 8'h00, q);
        chk("cksum_bad", 8'h01, {6'h00, q[7:6]});
        rdchk("thold_hi_reset", ADDR_PAR_HI, 8'h01);
    endtask

    initial begin
        ref_clk = 1'b0;
        reset = 1'b1;
        reg_req = '0;
        cfg_load_done = 1'b0;
        cfg_checksum_valid = 1'b1;
        pass_source = 1'b0;
        lock_source = 1'b0;
        parity_evt = '0;
        bc_txn_active = 1'b0;
        scl_in = 1'b1;
        sda_in = 1'b1;
        half_cyc = 8'h00;
        fails = 0;
        total_checks = 0;
        repeat (20) @(posedge ref_clk);
        reset <= 1'b0;
        t_reset();
        t_rw();
        t_init();
        t_pins();
        t_reference_clock_input();
        t_parity();
        t_remote();
        t_filter();
        t_wdog();
        t_cksum_bad();
        results();
    end

    // Whole run needs about 6600 cycles
    initial begin
        #300us;
        fails++;
        results();
    end
endmodule
